// ==== rtl/rtc_i2c_pkg.sv ====
// Shared constants for the two-wire target port of the clock chip
package rtc_i2c_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h68; // Fixed 7-bit target address (0xd0 >> 1)
    localparam int REG_AW = 8; // Register pointer width
    localparam logic [7:0] PTR_RESET = 8'h00; // Pointer value after reset
    localparam logic [3:0] BIT_LAST = 4'h7; // Index of the last data bit in a byte
    localparam logic [3:0] BIT_RESET = 4'h0; // Bit counter after reset
    localparam logic [7:0] BYTE_RESET = 8'h00; // Shift register after reset
    localparam int REG_DEPTH = 256; // Entries in the register file
    localparam int SYNC_STAGES = 3; // Flops on each pin input
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_PTR,
        ST_WDATA,
        ST_RDATA,
        ST_RACK,
        ST_WAIT
    } port_state_e;
endpackage

// ==== rtl/rtc_i2c_slave_port.sv ====
// Two-wire target port that reads and writes the clock chip register file
`timescale 1ns/1ps
module rtc_i2c_slave_port
    import rtc_i2c_pkg::*;
(
    input wire logic clk, // Core clock, 250 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic scl_i, // Bus clock level seen on the pin
    input wire logic sda_i, // Bus data level seen on the pin
    output logic scl_o, // Bus clock output value, always low
    output logic scl_oe, // Bus clock pull-down enable, never set
    output logic sda_o, // Bus data output value, always low
    output logic sda_oe, // Bus data pull-down enable
    output logic busy // High between START and STOP
);
    logic [SYNC_STAGES-1:0] scl_sync_reg; // Bus clock synchroniser
    logic [SYNC_STAGES-1:0] sda_sync_reg; // Bus data synchroniser
    logic scl_reg; // Filtered bus clock level
    logic sda_reg; // Filtered bus data level
    logic scl_rise; // Filtered bus clock rising
    logic scl_fall; // Filtered bus clock falling
    logic start_det; // START or repeated START seen
    logic stop_det; // STOP seen
    port_state_e state_reg; // Protocol state
    port_state_e state_next; // Protocol state next value
    logic [3:0] bit_cnt_reg; // Bit index inside a byte
    logic [7:0] shift_reg; // Receive and transmit shift register
    logic [7:0] ptr_reg; // Internal register pointer
    logic rw_reg; // Direction of the current transaction, 1 is read
    logic acked_reg; // Acked byte waiting for its data stage
    logic mem_we; // Register file write strobe
    logic [7:0] mem_rdata; // Register file read data
    logic sda_oe_next; // Data pull-down next value

    // Three flops per pin; a change counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_reg <= '1;
            sda_sync_reg <= '1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[SYNC_STAGES-2:0], scl_i};
            sda_sync_reg <= {sda_sync_reg[SYNC_STAGES-2:0], sda_i};
        end
    end

    // Filtered levels; idle bus rests high
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_reg <= sda_sync_reg[2];
            end
        end
    end

    // Edge and condition decode from agreeing synchroniser stages
    assign scl_rise = !scl_reg && (scl_sync_reg[1] == scl_sync_reg[2]) && scl_sync_reg[2];
    assign scl_fall = scl_reg && (scl_sync_reg[1] == scl_sync_reg[2]) && !scl_sync_reg[2];
    // Data change while clock high is a condition, never a data bit
    assign start_det = scl_reg && sda_reg && (sda_sync_reg[1] == sda_sync_reg[2])
                       && !sda_sync_reg[2];
    assign stop_det = scl_reg && !sda_reg && (sda_sync_reg[1] == sda_sync_reg[2])
                      && sda_sync_reg[2];

    // Transaction busy flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else if (stop_det) begin
            busy <= 1'b0;
        end else if (start_det) begin
            busy <= 1'b1;
        end
    end

    // Next protocol state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_ADDR: begin
                if (scl_fall && bit_cnt_reg == 4'h8) begin
                    // Address match decides between answering and waiting in ST_WAIT
                    if (shift_reg[7:1] == TARGET_ADDR) begin
                        state_next = ST_ACK;
                    end else begin
                        state_next = ST_WAIT;
                    end
                end
            end
            ST_ACK: begin
                // Ack lasts one clock pulse, ends at the ninth falling edge
                if (scl_fall) begin
                    if (rw_reg) begin
                        state_next = ST_RDATA;
                    end else if (acked_reg) begin
                        state_next = ST_WDATA;
                    end else begin
                        state_next = ST_PTR;
                    end
                end
            end
            ST_PTR, ST_WDATA: begin
                if (scl_fall && bit_cnt_reg == 4'h8) begin
                    state_next = ST_ACK;
                end
            end
            ST_RDATA: begin
                if (scl_fall && bit_cnt_reg == 4'h8) begin
                    state_next = ST_RACK;
                end
            end
            ST_RACK: begin
                // Sample controller ack on the ninth rising edge
                if (scl_rise) begin
                    state_next = sda_reg ? ST_WAIT : ST_RACK;
                end else if (scl_fall) begin
                    state_next = ST_RDATA;
                end
            end
            ST_IDLE, ST_WAIT: begin
                state_next = state_reg;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Conditions override everything; repeated START restarts address
        if (stop_det) begin
            state_next = ST_IDLE;
        end else if (start_det) begin
            state_next = ST_ADDR;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bit counter: counts sampled bits, clears at each byte boundary
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_reg <= BIT_RESET;
        end else if (start_det || state_next != state_reg) begin
            bit_cnt_reg <= BIT_RESET;
        end else if (scl_rise && bit_cnt_reg <= BIT_LAST) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // Shift register: sample MSB first on rising SCL, load on read entry
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg <= BYTE_RESET;
        end else if (state_reg == ST_RDATA) begin
            if (scl_fall) begin
                shift_reg <= {shift_reg[6:0], 1'b1};
            end
        end else if (state_next == ST_RDATA) begin
            shift_reg <= mem_rdata;
        end else if (scl_rise && bit_cnt_reg <= BIT_LAST) begin
            shift_reg <= {shift_reg[6:0], sda_reg};
        end
    end

    // Direction captured with the address byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rw_reg <= 1'b0;
            acked_reg <= 1'b0;
        end else if (state_reg == ST_ADDR && state_next == ST_ACK) begin
            rw_reg <= shift_reg[0];
            acked_reg <= 1'b0;
        end else if (state_reg == ST_ACK && state_next == ST_PTR) begin
            acked_reg <= 1'b1;
        end
    end

    // Pointer set by the first write byte, advanced after every data byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_reg <= PTR_RESET;
        end else if (state_reg == ST_PTR && state_next == ST_ACK) begin
            ptr_reg <= shift_reg;
        end else if (state_reg == ST_WDATA && state_next == ST_ACK) begin
            ptr_reg <= ptr_reg + 8'h01;
        end else if (state_reg == ST_RDATA && state_next == ST_RACK) begin
            ptr_reg <= ptr_reg + 8'h01;
        end
    end

    assign mem_we = (state_reg == ST_WDATA) && (state_next == ST_ACK);

    // Register file; read data follow the pointer one cycle later
    rtc_reg_mem #(
        .AW(REG_AW),
        .DEPTH(REG_DEPTH)
    ) u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(ptr_reg),
        .wdata(shift_reg),
        .raddr(ptr_reg),
        .rdata(mem_rdata)
    );

    // Data pull-down: ack low, or a zero bit held until SCL falls (else a false STOP)
    always_comb begin
        sda_oe_next = 1'b0;
        if (state_next == ST_ACK) begin
            sda_oe_next = 1'b1;
        end else if (state_next == ST_RDATA && state_reg == ST_RDATA) begin
            sda_oe_next = scl_fall ? !shift_reg[6] : !shift_reg[7];
        end else if (state_next == ST_RDATA) begin
            sda_oe_next = !mem_rdata[7];
        end
    end

    // Outputs only ever pull low or release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            scl_oe <= 1'b0;
        end else begin
            sda_oe <= sda_oe_next;
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            scl_oe <= 1'b0; // No clock stretching
        end
    end

    // Protocol checks: release after NACK or idle, conditions, line levels
    a_nack_release: assert property (@(posedge clk) disable iff (!rst_b)
        state_reg == ST_WAIT |-> ##1 !sda_oe) else $error("data driven after nack");
    a_idle_release: assert property (@(posedge clk) disable iff (!rst_b)
        state_reg == ST_IDLE && state_next == ST_IDLE |-> ##1 !sda_oe)
        else $error("data driven while idle");
    a_stop_idle: assert property (@(posedge clk) disable iff (!rst_b)
        stop_det |=> state_reg == ST_IDLE && !busy) else $error("stop not honoured");
    a_start_addr: assert property (@(posedge clk) disable iff (!rst_b)
        start_det && !stop_det |=> state_reg == ST_ADDR && busy)
        else $error("start not honoured");
    a_no_scl_drive: assert property (@(posedge clk) disable iff (!rst_b)
        !scl_oe && !sda_o) else $error("line driven high");
    // A transmitted bit that moves while SCL is high would read as START or STOP
    a_tx_hold_high: assert property (@(posedge clk) disable iff (!rst_b)
        state_reg == ST_RDATA && state_next == ST_RDATA && scl_reg && !scl_fall
        |=> $stable(sda_oe)) else $error("data changed while clock high");

    sequence s_byte_acked;
        state_reg == ST_WDATA && state_next == ST_ACK;
    endsequence
    a_ptr_inc: assert property (@(posedge clk) disable iff (!rst_b)
        s_byte_acked |=> ptr_reg == $past(ptr_reg) + 8'h01)
        else $error("pointer did not advance");
    a_ack_drive: assert property (@(posedge clk) disable iff (!rst_b)
        state_reg == ST_ADDR ##1 state_reg == ST_ACK |-> sda_oe)
        else $error("address not acked");
    a_addr_miss: assert property (@(posedge clk) disable iff (!rst_b)
        state_reg == ST_ADDR && scl_fall && bit_cnt_reg == 4'h8
        && shift_reg[7:1] != TARGET_ADDR && !start_det && !stop_det
        |=> state_reg == ST_WAIT) else $error("foreign address answered");
    a_mem_write: assert property (@(posedge clk) disable iff (!rst_b)
        mem_we |-> state_reg == ST_WDATA && acked_reg) else $error("write outside data");
endmodule

// ==== rtl/rtc_reg_mem.sv ====
// Register file of the clock chip with registered read data
`timescale 1ns/1ps
module rtc_reg_mem
    import rtc_i2c_pkg::*;
#(
    parameter int AW = REG_AW,
    parameter int DEPTH = REG_DEPTH
) (
    input wire logic clk, // Core clock
    input wire logic we, // Write strobe
    input wire logic [AW-1:0] waddr, // Write address
    input wire logic [7:0] wdata, // Write data
    input wire logic [AW-1:0] raddr, // Read address
    output logic [7:0] rdata // Registered read data
);
    logic [7:0] mem [DEPTH]; // Storage, no reset: contents start undefined

    // Write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read port, one cycle latency
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule

// ==== tb/i2c_ctrl_model.sv ====
// Bus controller model driving the target port from the far side
`timescale 1ns/1ps
module i2c_ctrl_model (
    input wire logic clk, // Core clock that paces the bus
    input wire logic scl_o, // Target clock output value
    input wire logic scl_oe, // Target clock pull-down enable
    input wire logic sda_o, // Target data output value
    input wire logic sda_oe, // Target data pull-down enable
    output logic scl_i, // Resolved clock line
    output logic sda_i // Resolved data line
);
    logic scl_low = 1'b0; // We pull the clock line low
    logic sda_low = 1'b0; // We pull the data line low
    logic in_frame = 1'b0; // Between START and STOP

    // Wired AND with pull-ups; a released line reads high
    assign scl_i = !scl_low && !(scl_oe && !scl_o);
    assign sda_i = !sda_low && !(sda_oe && !sda_o);

    // Waits whole core cycles, then steps just off the edge
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One bit of 8 core cycles: 5 low, 3 high, sampled late in the high phase
    task automatic bit_cyc(input logic b, output logic s);
        scl_low = 1'b1;
        tk(2);
        sda_low = !b;
        tk(3);
        scl_low = 1'b0;
        tk(3);
        s = sda_i;
    endtask

    // START, or a repeated START when a frame is already open
    task automatic start();
        if (in_frame) begin
            scl_low = 1'b1;
            tk(2);
            sda_low = 1'b0;
            tk(3);
            scl_low = 1'b0;
            tk(3);
        end
        sda_low = 1'b1;
        tk(5);
        in_frame = 1'b1;
    endtask

    // STOP; the clock then stands still high until the next frame
    task automatic stop();
        scl_low = 1'b1;
        tk(2);
        sda_low = 1'b1;
        tk(3);
        scl_low = 1'b0;
        tk(3);
        sda_low = 1'b0;
        tk(6);
        in_frame = 1'b0;
    endtask

    // Sends a byte MSB first and reports the acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], s);
        end
        bit_cyc(1'b1, s);
        ack = !s;
    endtask

    // Receives a byte, then acknowledges or withholds it
    task automatic rd_byte(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, s);
            d[i] = s;
        end
        bit_cyc(!give_ack, s);
    endtask
endmodule

// ==== tb/rtc_i2c_slave_port_tb.sv ====
// Self-checking bench for the two-wire target port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module rtc_i2c_slave_port_tb;
    typedef struct packed {logic [7:0] ptr; logic [7:0] data;} row_s;
    logic clk = 1'b0; // Core clock
    logic rst_b = 1'b0; // Reset, active low
    logic scl_i, sda_i, scl_o, scl_oe, sda_o, sda_oe, busy; // Port pins
    logic ack; // Acknowledge seen by the controller
    int mismatches = 0;
    int check_count = 0;
    // Pointer and data per row; test registers 0x49 and 0x4a are never used
    row_s rows [4] = '{'{8'h00, 8'h5a}, '{8'h48, 8'ha5}, '{8'h4b, 8'h3c}, '{8'hff, 8'hc3}};

    rtc_i2c_slave_port rtc_i2c_slave_port_inst (.clk(clk), .rst_b(rst_b), .scl_i(scl_i),
        .sda_i(sda_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
        .busy(busy));
    i2c_ctrl_model ctrl_inst (.clk(clk), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
        .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));

    // 250 MHz core clock
    always #2 clk = ~clk;

    // Prints the counts and the verdict, then ends the run
    task automatic test_done();
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Opens or reopens a frame; the port must report itself busy
    task automatic open_frame();
        ctrl_inst.start();
        `CHK("busy", 1'b1, busy)
    endtask

    // Sends one byte that must be acknowledged
    task automatic send_ok(input logic [7:0] d);
        ctrl_inst.wr_byte(d, ack);
        `CHK("ack", 1'b1, ack)
    endtask

    // Closes a frame; the port must go idle and leave the line high
    task automatic close_frame();
        ctrl_inst.stop();
        `CHK("busy", 1'b0, busy)
        `CHK("sda", 1'b1, sda_i)
        `CHK("sda_o", 1'b0, sda_o)
        `CHK("scl_o", 1'b0, scl_o)
    endtask

    // Write: address, pointer byte, then data at consecutive registers
    task automatic wr_seq(input logic [7:0] ptr, input logic [7:0] q[$]);
        open_frame();
        send_ok(8'hd0);
        send_ok(ptr);
        foreach (q[i]) send_ok(q[i]);
        close_frame();
    endtask

    // Standard read when set_ptr, else simplified read from the current pointer
    task automatic rd_seq(input logic set_ptr, input logic [7:0] ptr, input logic [7:0] q[$]);
        logic [7:0] d;
        open_frame();
        if (set_ptr) begin
            send_ok(8'hd0);
            send_ok(ptr);
            open_frame();
        end
        send_ok(8'hd1);
        foreach (q[i]) begin
            ctrl_inst.rd_byte(i < q.size() - 1, d);
            `CHK("rdata", q[i], d)
        end
        close_frame();
    endtask

    // Watchdog: a hung run counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("Error watchdog expected end seen timeout");
        test_done();
    end

    initial begin
        repeat (12) @(posedge clk);
        `CHK("busy", 1'b0, busy)
        `CHK("sda_oe", 1'b0, sda_oe)
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        // Ordinary cases: write one register, read it back
        for (int i = 0; i < 4; i++) begin
            wr_seq(rows[i].ptr, '{rows[i].data});
            rd_seq(1'b1, rows[i].ptr, '{rows[i].data});
            $display("Test row %0d done", i);
        end
        // Burst write, burst read of three, then a simplified read of the fourth
        wr_seq(8'h10, '{8'h11, 8'h22, 8'h33, 8'h44});
        rd_seq(1'b1, 8'h10, '{8'h11, 8'h22, 8'h33});
        rd_seq(1'b0, 8'h00, '{8'h44});
        $display("Test burst done");
        // Pointer wraps from the top register to the bottom one
        rd_seq(1'b1, 8'hff, '{8'hc3, 8'h5a});
        $display("Test wrap done");
        // Foreign address: no acknowledge, later bytes ignored too
        ctrl_inst.start();
        ctrl_inst.wr_byte(8'hd2, ack);
        `CHK("ack", 1'b0, ack)
        ctrl_inst.wr_byte(8'h00, ack);
        `CHK("ack", 1'b0, ack)
        close_frame();
        $display("Test foreign address done");
        // Reset in mid-frame drops busy; the pointer restarts at zero
        open_frame();
        send_ok(8'hd0);
        rst_b = 1'b0;
        ctrl_inst.tk(3);
        `CHK("busy", 1'b0, busy)
        `CHK("sda_oe", 1'b0, sda_oe)
        rst_b = 1'b1;
        ctrl_inst.tk(4);
        ctrl_inst.stop();
        rd_seq(1'b0, 8'h00, '{8'h5a});
        `CHK("scl_oe", 1'b0, scl_oe)
        $display("Test mid-frame reset done");
        test_done();
    end
endmodule
